// ==== core/urd_channel.sv ====
// one uart channel: host register decode, internal loopback, transmit buffer
`timescale 1ns/1ps
module urd_channel
	import urd_pkg::*;
#(
	parameter logic [7:0] REV_CODE = 8'h01, // arbitrary value
	parameter logic [7:0] DEV_ID = 8'h5a // arbitrary value
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic chan_select_n_i,
	input wire logic [2:0] addr_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_n_o,
	input wire logic tx_ser_i,
	output logic rx_ser_o,
	input wire logic rx_pin_i,
	output logic tx_pin_o,
	output logic rts_n_o,
	output logic dtr_n_o,
	input wire logic cts_n_i,
	input wire logic dsr_n_i,
	input wire logic cd_n_i,
	input wire logic ri_n_i,
	output logic [7:0] tx_data_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic tx_space_o,
	input wire logic tx_idle_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_valid_i,
	output logic rx_ready_o,
	input wire logic [3:0] line_err_i,
	input wire logic [7:0] int_status_i,
	input wire logic [7:0] fifo_level_i,
	output logic int_status_read_o,
	output logic [15:0] divisor_o,
	output logic [7:0] divisor_frac_o,
	output logic [7:0] line_control_o,
	output logic [7:0] interrupt_enable_o,
	output logic [7:0] fifo_control_o,
	output logic fifo_control_wr_o,
	output logic [7:0] trigger_level_o,
	output logic trigger_level_wr_o,
	output logic [7:0] feature_control_o,
	output logic [7:0] enhanced_function_o,
	output logic [7:0] enh_mode_o,
	output logic [31:0] flow_chars_o,
	output logic loopback_o,
	output logic auto_rts_enable_o
);

	// ==========================================================
	// state
	typedef struct packed {
		urd_phase_t ph;
		logic [7:0] dout;
		logic [7:0] dll;
		logic [7:0] divisor_high;
		logic [7:0] divisor_fraction;
		logic [7:0] interrupt_enable;
		logic [7:0] line_control;
		logic [7:0] modem_control;
		logic [7:0] scratch_pad;
		logic [7:0] feature_control;
		logic [7:0] enhanced_function;
		logic [7:0] enhanced_mode_select;
		logic [7:0] fifo_control;
		logic [7:0] fifo_trigger_level;
		logic [3:0][7:0] fch;
		logic fcr_wr;
		logic trg_wr;
		logic isr_rd;
		logic [3:0] mprev;
		logic [3:0] mdelta;
		logic rx_full;
		logic [7:0] rx_byte;
		logic [1:0][7:0] tb;
		logic [1:0] tcnt;
	} urd_state_t;

	urd_state_t s_reg;
	urd_state_t s_next;

	// ==========================================================
	// helpers
	function automatic urd_bank_t bank_of(input logic [7:0] line_control);
		if (line_control == ENH_BANK_KEY) begin
			return BANK_ENH;
		end else if (line_control[LCR_DIV_BIT]) begin
			return BANK_DIV;
		end else begin
			return BANK_NORM;
		end
	endfunction : bank_of

	logic loop;
	logic [3:0] modem_in;
	logic start_rd;
	logic start_wr;
	logic tx_pop;
	logic rx_take;
	urd_bank_t bank;
	logic [7:0] rd_val;

	assign loop = s_reg.modem_control[MCR_LOOP_BIT];
	assign bank = bank_of(s_reg.line_control);
	// modem inputs as active-high {cd, ri, dsr, cts}; in loopback the pins
	// are replaced by the channel's own control bits so software sees a
	// predictable pattern
	assign modem_in = loop ? {s_reg.modem_control[MCR_OP2_BIT], s_reg.modem_control[MCR_OP1_BIT],
		s_reg.modem_control[MCR_DTR_BIT], s_reg.modem_control[MCR_RTS_BIT]}
		: {~cd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i};
	assign start_rd = (s_reg.ph == PH_IDLE) && !chan_select_n_i && !rd_n_i;
	assign start_wr = (s_reg.ph == PH_IDLE) && !chan_select_n_i && !wr_n_i && rd_n_i;
	assign tx_pop = tx_valid_o && tx_ready_i;
	assign rx_take = rx_valid_i && !s_reg.rx_full;

	// ==========================================================
	// read decode
	always_comb begin
		rd_val = 8'h00;
		if (addr_i == ADDR_LCR) begin
			rd_val = s_reg.line_control;
		end else if (bank == BANK_ENH) begin
			case (addr_i)
				ADDR_HOLD: rd_val = fifo_level_i;
				ADDR_IER: rd_val = s_reg.feature_control;
				ADDR_ISR: rd_val = s_reg.enhanced_function;
				default: rd_val = s_reg.fch[addr_i[1:0]];
			endcase
		end else begin
			case (addr_i)
				ADDR_HOLD: begin
					if (bank == BANK_NORM) begin
						rd_val = s_reg.rx_byte;
					end else if (s_reg.dll == 8'h00 && s_reg.divisor_high == 8'h00) begin
						rd_val = REV_CODE;
					end else begin
						rd_val = s_reg.dll;
					end
				end
				ADDR_IER: begin
					if (bank == BANK_NORM) begin
						rd_val = s_reg.interrupt_enable;
					end else if (s_reg.dll == 8'h00 && s_reg.divisor_high == 8'h00) begin
						rd_val = DEV_ID;
					end else begin
						rd_val = s_reg.divisor_high;
					end
				end
				ADDR_ISR: begin
					if (bank == BANK_DIV && s_reg.enhanced_function[EFR_ENH_BIT]) begin
						rd_val = s_reg.divisor_fraction;
					end else begin
						rd_val = int_status_i;
					end
				end
				ADDR_MCR: rd_val = s_reg.modem_control;
				ADDR_LSR: rd_val = {1'b0, (s_reg.tcnt == 2'h0) && tx_idle_i,
					s_reg.tcnt == 2'h0, line_err_i, s_reg.rx_full};
				ADDR_MSR: rd_val = {modem_in, s_reg.mdelta};
				default: rd_val = s_reg.feature_control[FEATURE_CONTROL_FIFO_LEVEL_COUNTER_BIT] ? fifo_level_i : s_reg.scratch_pad;
			endcase
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		s_next = s_reg;
		s_next.fcr_wr = 1'b0;
		s_next.trg_wr = 1'b0;
		s_next.isr_rd = 1'b0;
		s_next.mprev = modem_in;
		case (s_reg.ph)
			PH_IDLE: begin
				if (start_wr) begin
					s_next.ph = PH_WR;
				end else if (start_rd) begin
					s_next.ph = PH_RD;
				end
			end
			PH_RD: begin
				if (rd_n_i || chan_select_n_i) begin
					s_next.ph = PH_IDLE;
				end
			end
			PH_WR: begin
				if (wr_n_i || chan_select_n_i) begin
					s_next.ph = PH_IDLE;
				end
			end
			default: s_next.ph = PH_IDLE;
		endcase
		// transmit buffer drain first; a full buffer drops host writes except in a cycle where an entry drains
		if (tx_pop) begin
			s_next.tb[0] = s_reg.tb[1];
			s_next.tcnt = s_reg.tcnt - 2'h1;
		end
		if (start_rd) begin
			s_next.dout = rd_val;
			if (addr_i == ADDR_HOLD && bank == BANK_NORM) begin
				s_next.rx_full = 1'b0;
			end
			if (addr_i == ADDR_ISR && bank != BANK_ENH && !(bank == BANK_DIV && s_reg.enhanced_function[EFR_ENH_BIT])) begin
				s_next.isr_rd = 1'b1;
			end
			if (addr_i == ADDR_MSR && bank != BANK_ENH) begin
				s_next.mdelta = 4'h0;
			end
		end
		// a byte arriving with the clearing read must not be lost: the set wins
		if (rx_take) begin
			s_next.rx_full = 1'b1;
			s_next.rx_byte = rx_data_i;
		end
		// a change seen in the same cycle as the clearing read still counts
		s_next.mdelta = s_next.mdelta | (modem_in ^ s_reg.mprev);
		if (start_wr) begin
			if (addr_i == ADDR_LCR) begin
				s_next.line_control = data_i;
			end else if (bank == BANK_ENH) begin
				case (addr_i)
					ADDR_HOLD: begin
						s_next.fifo_trigger_level = data_i;
						s_next.trg_wr = 1'b1;
					end
					ADDR_IER: s_next.feature_control = data_i;
					ADDR_ISR: s_next.enhanced_function = data_i;
					ADDR_MCR, ADDR_LSR, ADDR_MSR, ADDR_SPR: s_next.fch[addr_i[1:0]] = data_i;
					default: s_next.enhanced_function = s_reg.enhanced_function;
				endcase
			end else begin
				case (addr_i)
					ADDR_HOLD: begin
						if (bank == BANK_DIV) begin
							s_next.dll = data_i;
						end else if (s_next.tcnt < TXB_DEPTH) begin
							s_next.tb[s_next.tcnt[0]] = data_i;
							s_next.tcnt = s_next.tcnt + 2'h1;
						end
					end
					ADDR_IER: begin
						if (bank == BANK_DIV) begin
							s_next.divisor_high = data_i;
						end else begin
							s_next.interrupt_enable = data_i;
						end
					end
					ADDR_ISR: begin
						if (bank == BANK_DIV && s_reg.enhanced_function[EFR_ENH_BIT]) begin
							s_next.divisor_fraction = data_i;
						end else begin
							s_next.fifo_control = data_i;
							s_next.fcr_wr = 1'b1;
						end
					end
					ADDR_MCR: s_next.modem_control = data_i;
					ADDR_SPR: begin
						if (s_reg.feature_control[FEATURE_CONTROL_FIFO_LEVEL_COUNTER_BIT]) begin
							s_next.enhanced_mode_select = data_i;
						end else begin
							s_next.scratch_pad = data_i;
						end
					end
					default: s_next.scratch_pad = s_reg.scratch_pad;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_reg <= '0;
			s_reg.ph <= PH_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// outputs
	assign data_o = s_reg.dout;
	assign data_oe_n_o = (s_reg.ph != PH_RD);
	// the shift registers keep running in loopback, only the pins, rx_ser_o and auto_rts_enable_o change
	assign rx_ser_o = loop ? tx_ser_i : rx_pin_i;
	assign tx_pin_o = loop ? 1'b1 : tx_ser_i;
	assign rts_n_o = loop ? 1'b1 : ~s_reg.modem_control[MCR_RTS_BIT];
	assign dtr_n_o = loop ? 1'b1 : ~s_reg.modem_control[MCR_DTR_BIT];
	assign auto_rts_enable_o = s_reg.enhanced_function[EFR_ARTS_BIT] && !loop;
	assign tx_data_o = s_reg.tb[0];
	assign tx_valid_o = (s_reg.tcnt != 2'h0);
	assign tx_space_o = (s_reg.tcnt < TXB_DEPTH);
	assign rx_ready_o = !s_reg.rx_full;
	assign int_status_read_o = s_reg.isr_rd;
	assign divisor_o = {s_reg.divisor_high, s_reg.dll};
	assign divisor_frac_o = s_reg.divisor_fraction;
	assign line_control_o = s_reg.line_control;
	assign interrupt_enable_o = s_reg.interrupt_enable;
	assign fifo_control_o = s_reg.fifo_control;
	assign fifo_control_wr_o = s_reg.fcr_wr;
	assign trigger_level_o = s_reg.fifo_trigger_level;
	assign trigger_level_wr_o = s_reg.trg_wr;
	assign feature_control_o = s_reg.feature_control;
	assign enhanced_function_o = s_reg.enhanced_function;
	assign enh_mode_o = s_reg.enhanced_mode_select;
	assign flow_chars_o = s_reg.fch;
	assign loopback_o = loop;

	// ==========================================================
	// assertions
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_wr_at(logic [2:0] a);
		start_wr && addr_i == a;
	endsequence
	sequence s_rd_at(logic [2:0] a);
		start_rd && addr_i == a;
	endsequence

	a_loop_enter: assert property (s_wr_at(ADDR_MCR) ##0 bank != BANK_ENH |=>
		loopback_o == $past(data_i[MCR_LOOP_BIT])) else $error("loopback bit not followed");
	a_loop_route: assert property (loopback_o |-> rx_ser_o == tx_ser_i)
		else $error("loopback data path broken");
	a_pins_held: assert property (loopback_o |-> tx_pin_o && rts_n_o && dtr_n_o)
		else $error("pins not held in loopback");
	a_modem_ignored: assert property (loopback_o && $changed(cts_n_i) &&
		$stable(s_reg.modem_control) |=> s_reg.mdelta[0] == $past(s_reg.mdelta[0]))
		else $error("modem pin seen in loopback");
	a_auto_rts_off: assert property (loopback_o |-> !auto_rts_enable_o)
		else $error("auto flow control active in loopback");
	a_rx_read: assert property (s_rd_at(ADDR_HOLD) ##0 bank == BANK_NORM |=>
		data_o == $past(s_reg.rx_byte) && !data_oe_n_o && (rx_ready_o || $past(rx_valid_i)))
		else $error("receive byte not returned");
	a_tx_load: assert property (s_wr_at(ADDR_HOLD) ##0 bank == BANK_NORM &&
		s_reg.tcnt == 2'h0 && !tx_ready_i |=> tx_valid_o && tx_data_o == $past(data_i))
		else $error("transmit byte not loaded");
	a_rev_code: assert property (s_rd_at(ADDR_HOLD) ##0 bank == BANK_DIV &&
		divisor_o == 16'h0000 |=> data_o == REV_CODE) else $error("revision code wrong");
	a_lcr_always: assert property (s_wr_at(ADDR_LCR) |=>
		line_control_o == $past(data_i) && data_oe_n_o)
		else $error("line control not written");
	a_key_chars: assert property (s_wr_at(ADDR_MSR) ##0 bank == BANK_ENH |=>
		flow_chars_o[23:16] == $past(data_i) && $stable(s_reg.modem_control))
		else $error("stop character not written");

endmodule : urd_channel

// ==== include/urd_pkg.sv ====
// constants for the uart register decode and loopback channel
package urd_pkg;
	localparam logic [2:0] ADDR_HOLD = 3'h0;
	localparam logic [2:0] ADDR_IER = 3'h1;
	localparam logic [2:0] ADDR_ISR = 3'h2;
	localparam logic [2:0] ADDR_LCR = 3'h3;
	localparam logic [2:0] ADDR_MCR = 3'h4;
	localparam logic [2:0] ADDR_LSR = 3'h5;
	localparam logic [2:0] ADDR_MSR = 3'h6;
	localparam logic [2:0] ADDR_SPR = 3'h7;
	localparam logic [7:0] ENH_BANK_KEY = 8'hbf;
	localparam int LCR_DIV_BIT = 7;
	localparam int MCR_DTR_BIT = 0;
	localparam int MCR_RTS_BIT = 1;
	localparam int MCR_OP1_BIT = 2;
	localparam int MCR_OP2_BIT = 3;
	localparam int MCR_LOOP_BIT = 4;
	localparam int EFR_ENH_BIT = 4;
	localparam int EFR_ARTS_BIT = 6;
	localparam int FEATURE_CONTROL_FIFO_LEVEL_COUNTER_BIT = 6;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] TXB_DEPTH = 2'h2;
	typedef enum logic [1:0] {
		BANK_NORM = 2'h0,
		BANK_DIV = 2'h1,
		BANK_ENH = 2'h2
	} urd_bank_t;
	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_RD = 3'b010,
		PH_WR = 3'b100
	} urd_phase_t;
endpackage : urd_pkg

// ==== verification/uart_register_decode_loopback_test.sv ====
// self-checking bench for the register decode and loopback channel
`timescale 1ns/1ps
module uart_register_decode_loopback_test;
	import urd_pkg::*;
	logic ref_clk_i = 1'b0, resetn_i = 1'b0, tx_ser_i = 1'b1, rx_pin_i = 1'b1;
	logic cts_n_i = 1'b1, dsr_n_i = 1'b1, cd_n_i = 1'b1, ri_n_i = 1'b1;
	logic tx_ready_i = 1'b0, tx_idle_i = 1'b1, rx_valid_i = 1'b0;
	logic [7:0] rx_data_i = 8'h00, int_status_i = 8'hc1, fifo_level_i = 8'h2d;
	logic [3:0] line_err_i = 4'ha;
	logic chan_select_n_i, rd_n_i, wr_n_i, data_oe_n_o, rx_ser_o, tx_pin_o, rts_n_o;
	logic [2:0] addr_i;
	logic [7:0] data_i, data_o, tx_data_o, divisor_frac_o, line_control_o, enh_mode_o;
	logic [7:0] interrupt_enable_o, fifo_control_o, trigger_level_o, feature_control_o;
	logic [7:0] enhanced_function_o, q, q2;
	logic dtr_n_o, tx_valid_o, tx_space_o, rx_ready_o, int_status_read_o;
	logic fifo_control_wr_o, trigger_level_wr_o, loopback_o, auto_rts_enable_o;
	logic [15:0] divisor_o;
	logic [31:0] flow_chars_o;
	int errors = 0, samples_checked = 0, cycles = 0;

	always #5 ref_clk_i = ~ref_clk_i;

	urd_host_model i_host (.ref_clk_i, .rdata_i(data_o), .sel_n_o(chan_select_n_i),
		.addr_o(addr_i), .rd_n_o(rd_n_i), .wr_n_o(wr_n_i), .wdata_o(data_i));

	urd_channel i_dut (.ref_clk_i, .resetn_i, .chan_select_n_i, .addr_i, .rd_n_i, .wr_n_i,
		.data_i, .data_o, .data_oe_n_o, .tx_ser_i, .rx_ser_o, .rx_pin_i, .tx_pin_o, .rts_n_o,
		.dtr_n_o, .cts_n_i, .dsr_n_i, .cd_n_i, .ri_n_i, .tx_data_o, .tx_valid_o, .tx_ready_i,
		.tx_space_o, .tx_idle_i, .rx_data_i, .rx_valid_i, .rx_ready_o, .line_err_i,
		.int_status_i, .fifo_level_i, .int_status_read_o, .divisor_o, .divisor_frac_o,
		.line_control_o, .interrupt_enable_o, .fifo_control_o, .fifo_control_wr_o,
		.trigger_level_o, .trigger_level_wr_o, .feature_control_o, .enhanced_function_o,
		.enh_mode_o, .flow_chars_o, .loopback_o, .auto_rts_enable_o);

	// ==========================================================
	// shared helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		i_host.access(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		i_host.access(1'b0, a, 8'h00, q);
		check(q, exp);
	endtask : rd

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	// ==========================================================
	// scenarios
	task automatic t_normal_bank();
		wr(ADDR_LCR, 8'h03);
		rd(ADDR_LCR, 8'h03);
		wr(ADDR_IER, 8'h0f);
		rd(ADDR_IER, 8'h0f);
		check(interrupt_enable_o, 8'h0f);
		wr(ADDR_SPR, 8'h5c);
		rd(ADDR_SPR, 8'h5c);
		rd(ADDR_ISR, 8'hc1);
		wr(ADDR_ISR, 8'h07);
		check(fifo_control_o, 8'h07);
		i_host.access(1'b0, ADDR_LSR, 8'h00, q);
		check(q[4:1], 4'ha);
		$display("normal bank done");
	endtask : t_normal_bank

	task automatic t_divisor_bank();
		wr(ADDR_LCR, 8'h80);
		rd(ADDR_HOLD, 8'h01);
		rd(ADDR_IER, 8'h5a);
		wr(ADDR_HOLD, 8'h34);
		wr(ADDR_IER, 8'h12);
		check(divisor_o, 16'h1234);
		rd(ADDR_HOLD, 8'h34);
		rd(ADDR_IER, 8'h12);
		rd(ADDR_ISR, 8'hc1);
		$display("divisor bank done");
	endtask : t_divisor_bank

	task automatic t_key_bank();
		wr(ADDR_LCR, ENH_BANK_KEY);
		wr(ADDR_IER, 8'h40);
		rd(ADDR_IER, 8'h40);
		wr(ADDR_ISR, 8'h50);
		rd(ADDR_ISR, 8'h50);
		check(auto_rts_enable_o, 1'b1);
		wr(ADDR_HOLD, 8'h21);
		check(trigger_level_o, 8'h21);
		rd(ADDR_HOLD, 8'h2d);
		for (int i = 4; i < 8; i++) begin
			wr(3'(i), 8'hb0 + 8'(i));
		end
		check(flow_chars_o, 32'hb7b6b5b4);
		rd(ADDR_LCR, ENH_BANK_KEY);
		wr(ADDR_LCR, 8'h80);
		wr(ADDR_ISR, 8'h66);
		check(divisor_frac_o, 8'h66);
		wr(ADDR_LCR, 8'h03);
		rd(ADDR_SPR, 8'h2d);
		wr(ADDR_SPR, 8'h0c);
		check(enh_mode_o, 8'h0c);
		$display("enhanced bank done");
	endtask : t_key_bank

	task automatic t_loopback();
		wr(ADDR_MCR, 8'h03);
		check({rts_n_o, dtr_n_o}, 2'b00);
		tx_ser_i = 1'b0;
		#1;
		check(tx_pin_o, 1'b0);
		wr(ADDR_MCR, 8'h13);
		check(loopback_o, 1'b1);
		check({tx_pin_o, rts_n_o, dtr_n_o}, 3'b111);
		check(rx_ser_o, 1'b0);
		check(auto_rts_enable_o, 1'b0);
		tx_ser_i = 1'b1;
		#1;
		check(rx_ser_o, 1'b1);
		i_host.access(1'b0, ADDR_MSR, 8'h00, q);
		i_host.access(1'b0, ADDR_MSR, 8'h00, q2);
		check(q, 8'h33);
		check(q2, 8'h30);
		{cts_n_i, dsr_n_i, cd_n_i, ri_n_i} = 4'h0;
		rd(ADDR_MSR, 8'h30);
		tx_ser_i = 1'b0;
		wr(ADDR_MCR, 8'h03);
		// rx pin stays high through the whole loopback test
		check({loopback_o, rx_ser_o, tx_pin_o}, 3'b010);
		$display("loopback done");
	endtask : t_loopback

	task automatic t_streams();
		wr(ADDR_HOLD, 8'ha1);
		wr(ADDR_HOLD, 8'ha2);
		wr(ADDR_HOLD, 8'ha3);
		check({tx_space_o, tx_valid_o, tx_data_o}, {2'b01, 8'ha1});
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk_i);
			#1;
			tx_ready_i = 1'b1;
			@(posedge ref_clk_i);
			#1;
			tx_ready_i = 1'b0;
			check({tx_valid_o, tx_data_o}, (i == 0) ? 9'h1a2 : 9'h0a2);
		end
		rx_data_i = 8'h3c;
		rx_valid_i = 1'b1;
		@(posedge ref_clk_i);
		#1;
		rx_valid_i = 1'b0;
		check(rx_ready_o, 1'b0);
		rd(ADDR_HOLD, 8'h3c);
		check(rx_ready_o, 1'b1);
		$display("streams done");
	endtask : t_streams

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			final_report();
		end
	end

	initial begin
		repeat (10) @(posedge ref_clk_i);
		#1;
		resetn_i = 1'b1;
		t_normal_bank();
		t_divisor_bank();
		t_key_bank();
		t_loopback();
		t_streams();
		final_report();
	end
endmodule : uart_register_decode_loopback_test

// ==== verification/urd_host_model.sv ====
// host processor model: byte accesses on the channel's parallel register bus
`timescale 1ns/1ps
module urd_host_model (
	input wire logic ref_clk_i,
	input wire logic [7:0] rdata_i,
	output logic sel_n_o,
	output logic [2:0] addr_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic [7:0] wdata_o
);
	initial begin
		sel_n_o = 1'b1;
		addr_o = 3'h0;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		wdata_o = 8'h00;
	end

	// ==========================================================
	// one access per strobe, strobe high for two cycles in between
	task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge ref_clk_i);
		#1;
		sel_n_o = 1'b0;
		addr_o = a;
		wdata_o = d;
		rd_n_o = w;
		wr_n_o = !w;
		@(posedge ref_clk_i);
		#1;
		q = rdata_i;
		sel_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		// released lines are not left showing the last value
		addr_o = ~a;
		wdata_o = ~d;
		@(posedge ref_clk_i);
		// return off the edge so callers never change inputs in the sampling step
		#1;
	endtask : access
endmodule : urd_host_model
